// ### logic/fwpq_pkg.sv
// Purpose: Shared constants for the flash word program and query link.
// Assumes: One clock, commands and data carried as 16-bit words.
// Notes:   Query offsets are word addresses within the query space.
package fwpq_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h41;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_READ_QUERY = 8'h98;
    localparam int SR_READY = 7;
    localparam int SR_PFAIL = 4;
    localparam int SR_SUPPLY = 3;
    localparam int SR_LOCK = 1;
    localparam logic [15:0] Q_EBLK_LO = 16'h0135;
    localparam logic [15:0] Q_EBLK_HI = 16'h0136;
    localparam logic [15:0] Q_ENDUR_LO = 16'h0139;
    localparam logic [15:0] Q_ENDUR_HI = 16'h013a;
    localparam logic [15:0] Q_CELL_BITS = 16'h013b;
    localparam logic [15:0] Q_RW_CAP = 16'h013c;
    localparam logic [15:0] Q_PREG_BASE = 16'h013d;
    localparam int Q_PREG_LEN = 6;
    localparam logic [7:0] V_ENDUR_LO = 8'h64;
    localparam logic [7:0] V_ENDUR_HI = 8'h00;
    localparam logic [7:0] V_CELL_BITS = 8'h12;
    localparam logic [7:0] V_RW_CAP_MUX = 8'h02;
    localparam logic [7:0] V_RW_CAP_NONMUX = 8'h03;
    localparam logic [47:0] V_PREG = 48'h0010_0010_000a;
    localparam int PROG_TIME_NS = 2000;
    localparam int CLK_NS = 25;
    localparam int PROG_CYC = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;
endpackage

// ### logic/fwpq_if.sv
// Purpose: Bus between the host controller and the flash device model.
// Assumes: Synchronous single-cycle write and read strobes.
// Notes:   Read data is valid one cycle after the read strobe.
interface fwpq_if;
    import fwpq_pkg::*;
    logic              wr_stb;
    logic              rd_stb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    modport dev (input wr_stb, rd_stb, addr, wdata,
                 output rdata, rvalid);
    modport host (output wr_stb, rd_stb, addr, wdata,
                  input rdata, rvalid);
endinterface

// ### logic/fwpq_device.sv
// Purpose: Flash device end: word program, status and query answers.
// Assumes: Bus strobes synchronous to clk_sys_in; one partition.
// Notes:   Array storage is out of scope; a program only sets status.
module fwpq_device
#(
    parameter bit NON_MUX      = 1'b1,
    // Blocks per partition; the query reports this count less one.
    parameter int ERASE_BLOCKS = 16
)(
    input  wire logic    clk_sys_in,
    input  wire logic    arst_n_in,
    fwpq_if.dev          bus,
    input  wire logic    supply_ok_in,
    input  wire logic    block_locked_in,
    input  wire logic    verify_fail_in,
    output logic         busy_out,
    output logic [7:0]   status_out
);
    import fwpq_pkg::*;

    typedef enum logic [1:0] {M_ARRAY, M_STATUS, M_QUERY} fwpq_mode_t;
    typedef enum logic [1:0] {S_IDLE, S_SETUP, S_PROG} fwpq_st_t;

    typedef struct packed {
        fwpq_mode_t        mode;
        fwpq_st_t          st;
        logic [CNT_W-1:0]  cnt;
        logic              pfail;
        logic              supply;
        logic              lock;
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
        logic              busy;
        logic [7:0]        status;
    } fwpq_dev_state_t;

    fwpq_dev_state_t st_ff, nxt_st;

    function automatic logic [7:0] query_byte(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] k;
        k = a - Q_PREG_BASE;
        if (a == Q_EBLK_LO) query_byte = 8'(ERASE_BLOCKS - 1);
        else if (a == Q_EBLK_HI)
            query_byte = 8'((ERASE_BLOCKS - 1) >> 8);
        else if (a == Q_ENDUR_LO) query_byte = V_ENDUR_LO;
        else if (a == Q_ENDUR_HI) query_byte = V_ENDUR_HI;
        else if (a == Q_CELL_BITS) query_byte = V_CELL_BITS;
        else if (a == Q_RW_CAP)
            query_byte = NON_MUX ? V_RW_CAP_NONMUX : V_RW_CAP_MUX;
        else if (a >= Q_PREG_BASE && k < ADDR_W'(Q_PREG_LEN))
            // Bits 15 and 47 stay zero: region fields are meaningful.
            query_byte = V_PREG[k[2:0]*8 +: 8];
        else query_byte = 8'h00;
    endfunction

    function automatic logic [7:0] status_byte(input fwpq_dev_state_t s);
        status_byte = 8'h00;
        status_byte[SR_READY] = (s.st != S_PROG);
        status_byte[SR_PFAIL] = s.pfail;
        status_byte[SR_SUPPLY] = s.supply;
        status_byte[SR_LOCK] = s.lock;
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;
        if (st_ff.st == S_PROG) begin
            if (st_ff.cnt == '0) begin
                nxt_st.st = S_IDLE;
                if (verify_fail_in) begin
                    nxt_st.pfail = 1'b1;
                end
            end else begin
                nxt_st.cnt = st_ff.cnt - 1'b1;
            end
        end
        if (bus.wr_stb && st_ff.st != S_PROG) begin
            if (st_ff.st == S_SETUP) begin
                // Second write: the word itself starts the operation.
                nxt_st.mode = M_STATUS;
                if (st_ff.supply || !supply_ok_in) begin
                    nxt_st.supply = 1'b1;
                    nxt_st.st = S_IDLE;
                end else if (block_locked_in) begin
                    nxt_st.lock = 1'b1;
                    nxt_st.st = S_IDLE;
                end else begin
                    nxt_st.st = S_PROG;
                    nxt_st.cnt = CNT_W'(PROG_CYC - 1);
                end
            end else begin
                case (bus.wdata[7:0])
                    CMD_PROG_SETUP: nxt_st.st = S_SETUP;
                    CMD_READ_ARRAY: nxt_st.mode = M_ARRAY;
                    CMD_READ_STATUS: nxt_st.mode = M_STATUS;
                    CMD_READ_QUERY: nxt_st.mode = M_QUERY;
                    CMD_CLEAR_STATUS: begin
                        // Only this command clears the error flags.
                        nxt_st.pfail = 1'b0;
                        nxt_st.supply = 1'b0;
                        nxt_st.lock = 1'b0;
                    end
                    default: nxt_st.st = S_IDLE;
                endcase
            end
        end
        if (bus.rd_stb) begin
            nxt_st.rvalid = 1'b1;
            case (st_ff.mode)
                M_STATUS: nxt_st.rdata = {8'h00, status_byte(st_ff)};
                M_QUERY: nxt_st.rdata = {8'h00, query_byte(bus.addr)};
                M_ARRAY: nxt_st.rdata = {DATA_W{1'b1}};
                default: nxt_st.rdata = '0;
            endcase
        end
        // Registered so the pins carry no decode glitches.
        nxt_st.busy = (nxt_st.st == S_PROG);
        nxt_st.status = status_byte(nxt_st);
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_ff <= '{mode: M_ARRAY, st: S_IDLE, cnt: '0, pfail: 1'b0,
                       supply: 1'b0, lock: 1'b0, rdata: '0, rvalid: 1'b0,
                       busy: 1'b0, status: 8'h01 << SR_READY};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bus.rdata = st_ff.rdata;
    assign bus.rvalid = st_ff.rvalid;
    assign busy_out = st_ff.busy;
    assign status_out = st_ff.status;
endmodule

// ### logic/fwpq_host.sv
// Purpose: Host end: runs one word program and reports its status.
// Assumes: Device answers reads one cycle after the strobe.
// Notes:   Full error check is done after every word.
// Summary of operation
// - Program is setup 0x41 then data.
// - Ready bit low while busy, high after.
// - Host may check errors per word or batch.
// - Write 0xFF after last program: array read.
// - Supply error flag refuses further programs.
// - Failed word sets program fail flag.
// - Locked block aborts, sets lock flag.
// - Error flags cleared only by clear command.
// - Host clears status after any error.
// - Bits-per-cell query byte reads 0x12.
// - Capability byte reads 02 mux, 03 non-mux.
// - Endurance field reads 0x64, 0x00.
// - Programming region exponent byte reads 0A.
// - Control mode sizes both read 10.
// - Legacy bits 15 and 47 void fields.
// - Erase region low half holds block count less one.
module fwpq_host
(
    input  wire logic                        clk_sys_in,
    input  wire logic                        arst_n_in,
    fwpq_if.host                             bus,
    input  wire logic                        start_in,
    input  wire logic [fwpq_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [fwpq_pkg::DATA_W-1:0] data_in,
    output logic                             done_out,
    output logic [7:0]                       status_out
);
    import fwpq_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE, H_SETUP, H_DATA, H_POLL, H_WAIT, H_CLEAR, H_EXIT
    } fwpq_hst_t;

    typedef struct packed {
        fwpq_hst_t         st;
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] word;
        logic              done;
        logic [7:0]        status;
    } fwpq_host_state_t;

    fwpq_host_state_t st_ff, nxt_st;
    logic             err;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.wr = 1'b0;
        nxt_st.rd = 1'b0;
        nxt_st.done = 1'b0;
        err = bus.rdata[SR_PFAIL] | bus.rdata[SR_SUPPLY] | bus.rdata[SR_LOCK];
        case (st_ff.st)
            H_IDLE: if (start_in) begin
                nxt_st.word = data_in;
                nxt_st.addr = addr_in;
                nxt_st.st = H_SETUP;
            end
            H_SETUP: begin
                nxt_st.wr = 1'b1;
                nxt_st.wdata = {8'h00, CMD_PROG_SETUP};
                nxt_st.st = H_DATA;
            end
            H_DATA: begin
                nxt_st.wr = 1'b1;
                nxt_st.wdata = st_ff.word;
                nxt_st.st = H_POLL;
            end
            H_POLL: begin
                nxt_st.rd = 1'b1;
                nxt_st.st = H_WAIT;
            end
            H_WAIT: if (bus.rvalid) begin
                if (!bus.rdata[SR_READY]) begin
                    nxt_st.st = H_POLL;
                end else begin
                    // Errors checked after every word, one allowed choice.
                    nxt_st.status = bus.rdata[7:0];
                    nxt_st.st = err ? H_CLEAR : H_EXIT;
                end
            end
            H_CLEAR: begin
                nxt_st.wr = 1'b1;
                nxt_st.wdata = {8'h00, CMD_CLEAR_STATUS};
                nxt_st.st = H_EXIT;
            end
            H_EXIT: begin
                nxt_st.wr = 1'b1;
                nxt_st.wdata = {8'h00, CMD_READ_ARRAY};
                nxt_st.done = 1'b1;
                nxt_st.st = H_IDLE;
            end
            default: nxt_st.st = H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_ff <= '{st: H_IDLE, wr: 1'b0, rd: 1'b0, addr: '0, wdata: '0,
                       word: '0, done: 1'b0, status: 8'h00};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bus.wr_stb = st_ff.wr;
    assign bus.rd_stb = st_ff.rd;
    assign bus.addr = st_ff.addr;
    assign bus.wdata = st_ff.wdata;
    assign done_out = st_ff.done;
    assign status_out = st_ff.status;
endmodule

// ### verification/fwpq_chk.sv
// Purpose: Watches the bus between the host end and the device end.
// Assumes: The host drives the bus; the status byte is in rdata[7:0].
// Notes:   Pure observer; the address is checked to stay the same from the setup write to the data write.
module fwpq_chk
(
    input  wire logic                        clk_sys_in,
    input  wire logic                        arst_n_in,
    input  wire logic                        wr_stb,
    input  wire logic                        rd_stb,
    input  wire logic [fwpq_pkg::ADDR_W-1:0] addr,
    input  wire logic [fwpq_pkg::DATA_W-1:0] wdata,
    input  wire logic [fwpq_pkg::DATA_W-1:0] rdata,
    input  wire logic                        rvalid
);
    timeunit 1ns;
    timeprecision 100ps;
    import fwpq_pkg::*;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    wire logic setup = wr_stb && wdata[7:0] == CMD_PROG_SETUP;
    wire logic err = rdata[SR_PFAIL] | rdata[SR_SUPPLY] | rdata[SR_LOCK];
    wire logic rdy = rvalid && rdata[SR_READY];

    AST_READ_ANSWER: assert property (rd_stb |=> rvalid)
        else $error("read strobe not answered");
    AST_ANSWER_PULSE: assert property (!rd_stb |=> !rvalid)
        else $error("answer without a read");
    AST_ANSWER_HOLD: assert property (!rd_stb |=> $stable(rdata))
        else $error("read data changed without a read");
    AST_SETUP_THEN_DATA: assert property (setup |=> wr_stb)
        else $error("setup not followed by data write");
    AST_SAME_TARGET: assert property (setup |=> $stable(addr))
        else $error("data write went to another location");
    AST_FIRST_POLL_BUSY: assert property (setup ##1 wr_stb ##1 rd_stb
        |=> rvalid && !rdata[SR_READY])
        else $error("ready shown during programming");
    AST_READY_BOUND: assert property (setup ##1 wr_stb
        |-> ##[2:200] rdy)
        else $error("program never reported ready");
    AST_CLEAR_ON_ERROR: assert property (rdy && err
        |-> ##[1:8] (wr_stb && wdata[7:0] == CMD_CLEAR_STATUS))
        else $error("error flags not cleared by host");
    AST_ARRAY_AFTER: assert property (rdy
        |-> ##[1:8] (wr_stb && wdata[7:0] == CMD_READ_ARRAY))
        else $error("array read not restored");
endmodule

// ### verification/flash_word_program_and_query_info_tb.sv
// Purpose: Self-checking bench for the word program and query link.
// Assumes: Inputs change on the falling clock edge.
// Notes:   A second device is driven directly to reach queries and faults.
module flash_word_program_and_query_info_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import fwpq_pkg::*;
    logic        clk_sys_in;
    logic        arst_n_in;
    logic        start;
    logic        done;
    logic        vf1;
    logic        sup2;
    logic        lck2;
    logic        busy2;
    logic [7:0]  hst;
    logic [7:0]  dst1;
    logic [7:0]  dst2;
    logic [15:0] rd;
    int          failures;
    int          samples_checked;
    fwpq_if      bus1();
    fwpq_if      bus2();

    fwpq_host fwpq_host_inst (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .bus(bus1.host), .start_in(start), .addr_in(16'h0100),
        .data_in(16'h1234), .done_out(done), .status_out(hst));
    fwpq_device fwpq_device_inst (.clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in), .bus(bus1.dev), .supply_ok_in(1'b1),
        .block_locked_in(1'b0), .verify_fail_in(vf1), .busy_out(),
        .status_out(dst1));
    fwpq_device #(.NON_MUX(1'b0)) fwpq_device_inst2 (.clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in), .bus(bus2.dev), .supply_ok_in(sup2),
        .block_locked_in(lck2), .verify_fail_in(vf1), .busy_out(busy2),
        .status_out(dst2));
    fwpq_chk fwpq_chk_inst (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .wr_stb(bus1.wr_stb), .rd_stb(bus1.rd_stb), .addr(bus1.addr),
        .wdata(bus1.wdata), .rdata(bus1.rdata), .rvalid(bus1.rvalid));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr2(input logic [15:0] d);
        @(negedge clk_sys_in);
        bus2.wr_stb = 1'b1;
        bus2.wdata = d;
        @(negedge clk_sys_in);
        bus2.wr_stb = 1'b0;
    endtask
    task automatic rd2(input logic [15:0] a);
        @(negedge clk_sys_in);
        bus2.rd_stb = 1'b1;
        bus2.addr = a;
        @(negedge clk_sys_in);
        bus2.rd_stb = 1'b0;
        chk({15'h0, bus2.rvalid}, 16'h0001);
        rd = bus2.rdata;
    endtask
    task automatic st(input logic [15:0] exp);
        rd2(16'h0000);
        chk(rd & 16'h00ff, exp);
    endtask
    task automatic prog1(input logic fail, input logic [15:0] exp);
        int n;
        @(negedge clk_sys_in);
        vf1 = fail;
        start = 1'b1;
        @(negedge clk_sys_in);
        start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk({15'h0, done}, 16'h0001);
        chk({8'h0, hst}, exp);
        chk({8'h0, dst1}, 16'h0080);
    endtask
    task automatic query_table();
        logic [7:0] e [0:10];
        e = '{8'h64, 8'h00, 8'h12, 8'h02, 8'h0a, 8'h00, 8'h10, 8'h00,
              8'h10, 8'h00, 8'h00};
        wr2(16'h0098);
        for (int i = 0; i < 11; i++) begin
            rd2(16'h0139 + 16'(i));
            chk(rd & 16'hff, {8'h0, e[i]});
        end
        rd2(16'h0135);
        chk(rd & 16'hff, 16'h000f);
        rd2(16'h0136);
        chk(rd & 16'hff, 16'h0000);
        wr2(16'h00ff);
        rd2(16'h0139);
        chk(rd, 16'hffff);
    endtask
    task automatic prog_direct();
        wr2(16'h0041);
        wr2(16'h5a5a);
        st(16'h0000);
        chk({15'h0, busy2}, 16'h0001);
        repeat (PROG_CYC) @(negedge clk_sys_in);
        st(16'h0080);
    endtask
    task automatic lock_sticky();
        lck2 = 1'b1;
        wr2(16'h0041);
        wr2(16'h1111);
        lck2 = 1'b0;
        st(16'h0082);
        wr2(16'h00ff);
        wr2(16'h0070);
        st(16'h0082);
        wr2(16'h0050);
        wr2(16'h0070);
        st(16'h0080);
    endtask
    task automatic supply_refuse();
        sup2 = 1'b0;
        wr2(16'h0041);
        wr2(16'h2222);
        sup2 = 1'b1;
        st(16'h0088);
        wr2(16'h0041);
        wr2(16'h3333);
        st(16'h0088);
        chk({15'h0, busy2}, 16'h0000);
    endtask
    task automatic give_verdict();
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    // The whole sequence needs well under a thousand cycles; allow plenty.
    initial begin
        #100000;
        failures++;
        give_verdict();
    end
    initial begin
        failures = 0;
        samples_checked = 0;
        arst_n_in = 1'b0;
        start = 1'b0;
        vf1 = 1'b0;
        sup2 = 1'b1;
        lck2 = 1'b0;
        bus2.wr_stb = 1'b0;
        bus2.rd_stb = 1'b0;
        bus2.addr = 16'h0000;
        bus2.wdata = 16'h0000;
        repeat (8) @(negedge clk_sys_in);
        arst_n_in = 1'b1;
        chk({8'h0, dst2}, 16'h0080);
        prog1(1'b0, 16'h0080);
        prog1(1'b1, 16'h0090);
        vf1 = 1'b0;
        query_table();
        prog_direct();
        lock_sticky();
        supply_refuse();
        give_verdict();
    end
endmodule
